// ---- logic/irs_sequencer.sv ----
// Internal reset sequencer with free-running counter and watchdog.
`timescale 1ns/1ps
`include "irs_cfg.svh"
// =============================================================
// Overview of operation
// - After power-on the reset pin is a plain input until enabled.
// - Reset pin is driven only while reset_pin_enable is set.
// - Power-on and low-voltage hold the pin low for 4096 cycles first.
// - Watchdog timeout input is accepted asynchronously through a synchroniser.
// - Every internal source drives the pin low for 32 cycles.
// - Internal reset stays asserted 35 more cycles after pin release.
// - Recovery totals 4163 cycles for power-on and low-voltage, 67 otherwise.
// - Power-on asserts reset, enables oscillator, gates clocks 4096 cycles.
// - Power-on sets the power-on cause flag.
// - Watchdog overflow resets and sets the watchdog flag.
// - Any write to FFFF clears the watchdog and counter stages 12 to 5.
// - Watchdog clock pulses at most once every 4080 cycles.
// - Watchdog halts during monitor break when break_watchdog_disable is set.
// - Illegal instruction decode sets the illegal opcode flag and resets.
// - Stop with stop_enable clear is an illegal opcode reset.
// - Opcode fetch from unmapped space sets illegal address flag and resets.
// - Data reads from unmapped space cause no reset.
// - Low voltage sets its flag, holds pin until 4128 cycles after recovery.
// - Twelve counting stages plus a thirteenth that wraps and clocks watchdog.
// - The counter advances on the falling edge of the fast clock.
// - Stop clears the counter; recovery is 32 or 4096 cycles.
// - External pin reset leaves the counter alone; counter then runs freely.
// - Internal resets clear the counter; each source sets its own flag.
module irs_sequencer (
   // Clock and power-on reset
   input wire logic clk,
   input wire logic rst,
   // Configuration
   input wire irs_pkg::irs_cfg_t cfg,
   // Processor status
   input wire irs_pkg::irs_cpu_t cpu,
   input wire logic wake_event,
   input wire logic break_active,
   input wire logic monitor_mode,
   // Asynchronous sources
   input wire logic low_voltage_in,
   input wire logic watchdog_timeout_in,
   input wire logic rst_pin_in,
   // Cause register clear
   input wire logic cause_clear,
   // Reset pin
   output logic rst_pin_out,
   output logic rst_pin_oe,
   // System outputs
   output logic internal_reset,
   output logic bus_clk_en,
   output logic osc_enable,
   output logic wdog_tick,
   output irs_pkg::irs_cause_t cause
);

   // =============================================================
   // Helpers
   function automatic logic seq_done(
      input logic [`IRS_CNT_W-1:0] c,
      input logic [`IRS_CNT_W-1:0] n
   );
      seq_done = (c == n - 13'h0001);
   endfunction : seq_done

   // =============================================================
   // Declarations
   irs_pkg::irs_state_t st_r;
   irs_pkg::irs_state_t st_nxt;
   irs_pkg::irs_cause_t cause_r;
   irs_pkg::irs_cause_t cause_set;
   logic [`IRS_CNT_W-1:0] cnt_r;
   logic [`IRS_WDOG_W-1:0] wdog_cnt_r;
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic lvi_s;
   logic wdog_in_s;
   logic wdog_in_d_r;
   logic pin_low_s;
   logic internal_reset_r;
   logic bus_clk_en_r;
   logic osc_enable_r;
   logic rst_pin_oe_r;
   logic rst_pin_out_r;
   logic wdog_tick_r;
   logic restart;
   logic clr_cnt;
   logic service;
   logic wdog_run;
   logic wdog_ovf;
   logic wdog_evt;
   logic illegal_opcode_flag_evt;
   logic illegal_address_flag_evt;
   logic ext_evt;
   logic [`IRS_CNT_W-1:0] srec_len;

   // =============================================================
   // Synchronisers for the pin-level sources
   // The whole block runs on the falling edge so the counter and the
   // sequencer never hand data across edges.
   always_ff @(negedge clk) begin
      if (rst) begin
         sync1_r <= `IRS_SYNC_RST;
         sync2_r <= `IRS_SYNC_RST;
         wdog_in_d_r <= 1'b0;
      end else begin
         sync1_r <= {rst_pin_in, watchdog_timeout_in, low_voltage_in};
         sync2_r <= sync1_r;
         wdog_in_d_r <= sync2_r[1];
      end
   end

   assign lvi_s = sync2_r[0];
   assign wdog_in_s = sync2_r[1];
   assign pin_low_s = !sync2_r[2];

   // =============================================================
   // Event decode
   assign illegal_opcode_flag_evt = cpu.ill_decode || (cpu.stop_exec && !cfg.stop_enable);
   assign illegal_address_flag_evt = cpu.fetch && cpu.unmapped;
   assign service = (st_r == irs_pkg::S_RUN) && cpu.wr
      && (cpu.addr == `IRS_SERVICE_ADDR);
   assign wdog_run = (st_r == irs_pkg::S_RUN)
      && !(break_active && monitor_mode && cfg.break_watchdog_disable);
   assign wdog_ovf = wdog_run && wdog_tick_r && (wdog_cnt_r == `IRS_WDOG_TERM);
   // Only the rising edge counts, so a timeout held for several cycles restarts once.
   assign wdog_evt = wdog_ovf || (wdog_in_s && !wdog_in_d_r);
   // Pin reset is only seen when the pin is enabled and not driven by us.
   assign ext_evt = (st_r == irs_pkg::S_RUN) && cfg.reset_pin_enable
      && !rst_pin_oe_r && pin_low_s;
   assign srec_len = cfg.short_stop_recovery ? `IRS_SHORT_CNT : `IRS_LONG_CNT;

   // =============================================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      restart = 1'b0;
      case (st_r)
         irs_pkg::S_RUN: begin
            if (ext_evt) begin
               st_nxt = irs_pkg::S_EXT;
            end else if (cpu.stop_exec && cfg.stop_enable) begin
               st_nxt = irs_pkg::S_STOP;
            end
         end
         irs_pkg::S_LONG: begin
            if (seq_done(cnt_r, `IRS_LONG_CNT)) begin
               st_nxt = irs_pkg::S_PIN;
            end
         end
         irs_pkg::S_PIN: begin
            if (seq_done(cnt_r, `IRS_PIN_CNT)) begin
               st_nxt = irs_pkg::S_INTERNAL_RESET;
            end
         end
         irs_pkg::S_INTERNAL_RESET: begin
            if (seq_done(cnt_r, `IRS_INTERNAL_RESET_CNT)) begin
               st_nxt = irs_pkg::S_TAIL;
            end
         end
         irs_pkg::S_TAIL: begin
            if (seq_done(cnt_r, `IRS_TAIL_CNT)) begin
               st_nxt = irs_pkg::S_RUN;
            end
         end
         irs_pkg::S_LVI: begin
            if (!lvi_s) begin
               st_nxt = irs_pkg::S_LONG;
            end
         end
         irs_pkg::S_STOP: begin
            if (wake_event) begin
               st_nxt = irs_pkg::S_SREC;
            end
         end
         irs_pkg::S_SREC: begin
            if (seq_done(cnt_r, srec_len)) begin
               st_nxt = irs_pkg::S_RUN;
            end
         end
         irs_pkg::S_EXT: begin
            if (!pin_low_s) begin
               st_nxt = irs_pkg::S_RUN;
            end
         end
         default: begin
            st_nxt = irs_pkg::S_LONG;
         end
      endcase
      // A fresh low-voltage or watchdog cause always restarts from its own first phase; illegal opcode and address causes do so only in run.
      if (lvi_s) begin
         st_nxt = irs_pkg::S_LVI;
         restart = 1'b1;
      end else if (wdog_evt) begin
         st_nxt = irs_pkg::S_PIN;
         restart = 1'b1;
      end else if ((st_r == irs_pkg::S_RUN) && (illegal_opcode_flag_evt || illegal_address_flag_evt)) begin
         st_nxt = irs_pkg::S_PIN;
         restart = 1'b1;
      end
   end

   // Every change of phase or internal restart clears the counter, so run
   // starts below the wrap point, but the pin reset path leaves it running.
   assign clr_cnt = ((st_nxt != st_r) && (st_r != irs_pkg::S_EXT)
      && (st_nxt != irs_pkg::S_EXT)) || restart;

   always_ff @(negedge clk) begin
      if (rst) begin
         st_r <= irs_pkg::S_LONG;
      end else begin
         st_r <= st_nxt;
      end
   end

   // =============================================================
   // Free-running counter: twelve stages plus the wrap stage
   always_ff @(negedge clk) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (clr_cnt || (st_r == irs_pkg::S_STOP)) begin
         cnt_r <= '0;
      end else if (service) begin
         cnt_r <= {cnt_r[12], 8'h00, cnt_r[3:0]};
      end else if (((st_r == irs_pkg::S_RUN) || (st_r == irs_pkg::S_EXT))
         && (cnt_r == `IRS_FREE_TERM)) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_r + 13'h0001;
      end
   end

   always_ff @(negedge clk) begin
      if (rst) begin
         wdog_tick_r <= 1'b0;
      end else begin
         wdog_tick_r <= (st_r == irs_pkg::S_RUN) && !service && !clr_cnt
            && (cnt_r == `IRS_FREE_TERM);
      end
   end

   // =============================================================
   // Watchdog counter
   always_ff @(negedge clk) begin
      if (rst) begin
         wdog_cnt_r <= '0;
      end else if (service || (st_r != irs_pkg::S_RUN) || wdog_ovf) begin
         wdog_cnt_r <= '0;
      end else if (wdog_run && wdog_tick_r) begin
         wdog_cnt_r <= wdog_cnt_r + 8'h01;
      end
   end

   // =============================================================
   // Reset cause register; a set in the clear cycle wins
   always_comb begin
      cause_set = '0;
      cause_set.low_voltage = lvi_s;
      cause_set.watchdog = wdog_evt;
      cause_set.pin = ext_evt;
      cause_set.illegal_opcode_flag = (st_r == irs_pkg::S_RUN) && illegal_opcode_flag_evt;
      cause_set.illegal_address_flag = (st_r == irs_pkg::S_RUN) && illegal_address_flag_evt;
   end

   always_ff @(negedge clk) begin
      if (rst) begin
         cause_r <= `IRS_CAUSE_RST;
      end else if (cause_clear) begin
         cause_r <= cause_set;
      end else begin
         cause_r <= cause_r | cause_set;
      end
   end

   // =============================================================
   // Registered outputs
   always_ff @(negedge clk) begin
      if (rst) begin
         internal_reset_r <= 1'b1;
         bus_clk_en_r <= 1'b0;
         osc_enable_r <= 1'b1;
      end else begin
         internal_reset_r <= (st_nxt != irs_pkg::S_RUN)
            && (st_nxt != irs_pkg::S_STOP) && (st_nxt != irs_pkg::S_SREC);
         bus_clk_en_r <= (st_nxt != irs_pkg::S_LONG) && (st_nxt != irs_pkg::S_LVI)
            && (st_nxt != irs_pkg::S_STOP) && (st_nxt != irs_pkg::S_SREC);
         osc_enable_r <= (st_nxt != irs_pkg::S_STOP);
      end
   end

   always_ff @(negedge clk) begin
      if (rst) begin
         rst_pin_oe_r <= 1'b0;
         rst_pin_out_r <= 1'b0;
      end else begin
         rst_pin_oe_r <= cfg.reset_pin_enable && ((st_nxt == irs_pkg::S_LONG)
            || (st_nxt == irs_pkg::S_PIN) || (st_nxt == irs_pkg::S_LVI));
         rst_pin_out_r <= 1'b0;
      end
   end

   assign rst_pin_out = rst_pin_out_r;
   assign rst_pin_oe = rst_pin_oe_r;
   assign internal_reset = internal_reset_r;
   assign bus_clk_en = bus_clk_en_r;
   assign osc_enable = osc_enable_r;
   assign wdog_tick = wdog_tick_r;
   assign cause = cause_r;

   // =============================================================
   // Assertions
   default clocking cb @(negedge clk);
   endclocking
   default disable iff (rst);

   a_pin_needs_enable: assert property (
      rst_pin_oe_r |-> $past(cfg.reset_pin_enable))
      else $error("Reset pin driven while disabled.");
   a_pin_low_only: assert property (
      rst_pin_oe_r |-> !rst_pin_out_r)
      else $error("Reset pin driven high.");
   a_long_phase_len: assert property (
      (st_r == irs_pkg::S_LONG) && (st_nxt == irs_pkg::S_PIN) && !restart
      |-> cnt_r == 13'h0FFF)
      else $error("Long hold phase has wrong length.");
   a_pin_phase_len: assert property (
      (st_r == irs_pkg::S_PIN) && !restart |=> (st_r == irs_pkg::S_INTERNAL_RESET)
      |-> $past(cnt_r) == 13'h001F)
      else $error("Pin low phase has wrong length.");
   a_internal_reset_tail_len: assert property (
      $rose(st_r == irs_pkg::S_TAIL) |-> (internal_reset_r && !rst_pin_oe_r)[*3]
      ##1 (st_r == irs_pkg::S_RUN) || restart)
      else $error("Tail of internal reset wrong.");
   a_wdog_resets: assert property (
      wdog_ovf && !lvi_s |=> (st_r == irs_pkg::S_PIN) && cause_r.watchdog
      ##1 internal_reset_r)
      else $error("Watchdog overflow did not reset.");
   a_service_clears: assert property (
      service |=> (wdog_cnt_r == 8'h00) && (cnt_r[11:4] == 8'h00))
      else $error("Service did not clear counters.");
   a_wdog_halted: assert property (
      (st_r == irs_pkg::S_RUN) && !wdog_run && !service |=> $stable(wdog_cnt_r))
      else $error("Watchdog advanced during a monitor break.");
   a_free_run_wrap: assert property (
      (st_r == irs_pkg::S_RUN) |-> cnt_r <= `IRS_FREE_TERM)
      else $error("Free counter passed its wrap point.");
   a_illegal_opcode_flag_resets: assert property (
      (st_r == irs_pkg::S_RUN) && illegal_opcode_flag_evt && !lvi_s && !wdog_evt
      |=> cause_r.illegal_opcode_flag && (st_r == irs_pkg::S_PIN))
      else $error("Illegal opcode did not reset.");
   a_data_read_safe: assert property (
      (st_r == irs_pkg::S_RUN) && cpu.unmapped && !cpu.fetch && !illegal_opcode_flag_evt
      && !wdog_evt && !lvi_s && !ext_evt && !cpu.stop_exec
      |=> (st_r == irs_pkg::S_RUN) && !internal_reset_r)
      else $error("Data read from unmapped space reset.");
   a_short_stop: assert property (
      (st_r == irs_pkg::S_SREC) && cfg.short_stop_recovery && (cnt_r == 13'h001F)
      && !lvi_s && !wdog_evt |=> (st_r == irs_pkg::S_RUN) ##1 bus_clk_en_r)
      else $error("Short stop recovery wrong.");

   c_por_done: cover property ($fell(internal_reset_r) && cause_r.por);
   c_wdog_reset: cover property (wdog_ovf);
   c_stop_wake: cover property ((st_r == irs_pkg::S_SREC) ##1 (st_r == irs_pkg::S_RUN));
   c_lvi_seq: cover property ($fell(st_r == irs_pkg::S_LVI));

endmodule : irs_sequencer

// ---- logic/irs_cfg.svh ----
// Constants for the internal reset sequencer: counts, reset values, addresses.
`ifndef IRS_CFG_SVH
`define IRS_CFG_SVH

// =============================================================
// Counter widths and sequence lengths in fast-clock cycles
`define IRS_CNT_W 13
`define IRS_LONG_CNT 13'h1000
`define IRS_PIN_CNT 13'h0020
`define IRS_INTERNAL_RESET_CNT 13'h0020
`define IRS_TAIL_CNT 13'h0003
`define IRS_SHORT_CNT 13'h0020
`define IRS_FREE_TERM 13'h0FEF

// =============================================================
// Watchdog
`define IRS_WDOG_W 8
`define IRS_WDOG_TERM 8'hFF
`define IRS_SERVICE_ADDR 16'hFFFF

// =============================================================
// Reset values
`define IRS_CAUSE_RST 6'h20
`define IRS_SYNC_RST 3'h4

`endif

// ---- logic/irs_pkg.sv ----
// Types shared by the internal reset sequencer.
package irs_pkg;

   // =============================================================
   // Sequencer states, one-hot
   typedef enum logic [8:0] {
      S_RUN  = 9'h001,
      S_LONG = 9'h002,
      S_PIN  = 9'h004,
      S_INTERNAL_RESET = 9'h008,
      S_TAIL = 9'h010,
      S_LVI  = 9'h020,
      S_STOP = 9'h040,
      S_SREC = 9'h080,
      S_EXT  = 9'h100
   } irs_state_t;

   // =============================================================
   // Reset cause register
   typedef struct packed {
      logic por;
      logic pin;
      logic watchdog;
      logic illegal_opcode_flag;
      logic illegal_address_flag;
      logic low_voltage;
   } irs_cause_t;

   // =============================================================
   // Processor status for decoding
   typedef struct packed {
      logic [15:0] addr;
      logic wr;
      logic fetch;
      logic unmapped;
      logic ill_decode;
      logic stop_exec;
   } irs_cpu_t;

   // =============================================================
   // Configuration bits
   typedef struct packed {
      logic reset_pin_enable;
      logic short_stop_recovery;
      logic stop_enable;
      logic break_watchdog_disable;
   } irs_cfg_t;

endpackage : irs_pkg

// ---- test/irs_ext_chip.sv ----
// Model of an external chip that shares the reset wire with the sequencer.
`timescale 1ns/1ps
module irs_ext_chip (
   // Clock
   input wire logic clk,
   // Drivers of the wire
   input wire logic dev_oe,
   input wire logic dev_out,
   input wire logic pull_low,
   // Wire level and time spent in reset
   output logic pin,
   output int low_cnt
);
   // ====
   // The wire has a pullup, so any party that drives low wins.
   assign pin = ((dev_oe && !dev_out) || pull_low) ? 1'b0 : 1'b1;

   // ====
   // The chip counts the cycles it is held in reset.
   int held = 0;
   assign low_cnt = held;
   always @(negedge clk) begin
      if (pin == 1'b0) begin
         held <= held + 1;
      end
   end
endmodule : irs_ext_chip

// ---- test/irs_sequencer_tb.sv ----
// Self-checking bench for the internal reset sequencer.
`timescale 1ns/1ps
module irs_sequencer_tb;
   // ====
   // Stimulus and observed signals
   logic clk = 1'b0;
   logic rst = 1'b1;
   irs_pkg::irs_cfg_t cfg = '0;
   irs_pkg::irs_cpu_t cpu = '0;
   logic wake_event = 1'b0;
   logic break_active = 1'b0;
   logic monitor_mode = 1'b0;
   logic low_voltage_in = 1'b0;
   logic watchdog_timeout_in = 1'b0;
   logic cause_clear = 1'b0;
   logic pull_low = 1'b0;
   logic pin, rst_pin_out, rst_pin_oe, internal_reset, bus_clk_en, osc_enable, wdog_tick;
   irs_pkg::irs_cause_t cause;
   logic [5:0] exp_cause;
   logic [31:0] r;
   int low_cnt, n_oe, n_ir, n_off, base, k, g;
   int miscompares = 0;
   int n_compared = 0;
   int seed = 32'h1796;

   irs_sequencer i_irs_sequencer (.clk(clk), .rst(rst), .cfg(cfg), .cpu(cpu),
      .wake_event(wake_event), .break_active(break_active), .monitor_mode(monitor_mode),
      .low_voltage_in(low_voltage_in), .watchdog_timeout_in(watchdog_timeout_in),
      .rst_pin_in(pin), .cause_clear(cause_clear), .rst_pin_out(rst_pin_out),
      .rst_pin_oe(rst_pin_oe), .internal_reset(internal_reset), .bus_clk_en(bus_clk_en),
      .osc_enable(osc_enable), .wdog_tick(wdog_tick), .cause(cause));
   irs_ext_chip i_irs_ext_chip (.clk(clk), .dev_oe(rst_pin_oe), .dev_out(rst_pin_out),
      .pull_low(pull_low), .pin(pin), .low_cnt(low_cnt));

   always #10 clk = ~clk;

   // ====
   // Helpers
   task automatic chk(string what, logic [31:0] lo, logic [31:0] hi, logic [31:0] got);
      n_compared++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         miscompares++;
         $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : chk

   function automatic logic [5:0] flag_of(int k);
      return k == 0 ? 6'h08 : (k == 3 ? 6'h02 : 6'h04);
   endfunction : flag_of

   task automatic fire(int k);
      @(posedge clk);
      case (k)
         0: watchdog_timeout_in <= 1'b1;
         1: cpu.ill_decode <= 1'b1;
         2: cpu.stop_exec <= 1'b1;
         3: cpu <= {16'h0000, 5'h0C};
         default: low_voltage_in <= 1'b1;
      endcase
   endtask : fire

   // Counts cycles of pin drive, reset and stopped clocks until reset ends.
   task automatic seq();
      bit seen;
      seen = 0;
      n_oe = 0;
      n_ir = 0;
      n_off = 0;
      for (int i = 0; i < 6000; i++) begin
         @(negedge clk);
         #1;
         n_oe += (rst_pin_oe === 1'b1);
         n_ir += (internal_reset === 1'b1);
         n_off += (bus_clk_en === 1'b0);
         if (internal_reset === 1'b1) seen = 1;
         if (seen && internal_reset === 1'b0) break;
         @(posedge clk);
         if (i == 2) begin
            cpu <= '0;
            watchdog_timeout_in <= 1'b0;
         end
      end
   endtask : seq

   // Cycles between two ticks, with an optional service write after svc cycles.
   task automatic tick_gap(int svc, output int gap);
      for (int i = 0; i < 5000; i++) begin
         @(negedge clk);
         #1;
         if (wdog_tick === 1'b1) break;
      end
      for (gap = 1; gap < 9000; gap++) begin
         @(posedge clk);
         cpu.wr <= (gap == svc);
         cpu.addr <= 16'hFFFF;
         @(negedge clk);
         #1;
         if (wdog_tick === 1'b1) break;
      end
   endtask : tick_gap

   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up

   // ====
   // Main sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      seq();
      // The cycle in which reset is released is already the first of the sequence.
      chk("power-on reset", 4163, 4164, n_ir + 1);
      chk("pin drive", 0, 0, n_oe);
      chk("clocks off", 4096, 4097, n_off + 1);
      chk("cause", 6'h20, 6'h20, cause);
      chk("oscillator", 1, 1, osc_enable);
      $display("test power_on done");
      exp_cause = 6'h20;
      @(posedge clk);
      cfg.reset_pin_enable <= 1'b1;
      for (k = 0; k < 4; k++) begin
         base = low_cnt;
         fire(k);
         seq();
         exp_cause |= flag_of(k);
         chk("pin low", 32, 32, n_oe);
         chk("chip reset", 32, 32, low_cnt - base);
         chk("internal reset", 67, 67, n_ir);
         chk("cause", exp_cause, exp_cause, cause);
      end
      $display("test internal_sources done");
      fire(4);
      repeat (20) @(posedge clk);
      low_voltage_in <= 1'b0;
      seq();
      exp_cause |= 6'h01;
      chk("low-voltage reset", 4163, 4166, n_ir);
      chk("low-voltage pin", 4128, 4131, n_oe);
      chk("cause", exp_cause, exp_cause, cause);
      $display("test low_voltage done");
      @(posedge clk);
      cause_clear <= 1'b1;
      @(posedge clk);
      cause_clear <= 1'b0;
      k = 0;
      // Random traffic never fetches from unmapped space.
      repeat (300) begin
         @(posedge clk);
         r = $random(seed);
         cpu <= {r[15:0], r[16], r[17], r[18] & ~r[17], 2'h0};
         @(negedge clk);
         #1;
         k += (internal_reset !== 1'b0);
      end
      chk("resets from data access", 0, 0, k);
      chk("cleared cause", 0, 0, cause);
      $display("test random_traffic done");
      tick_gap(0, g);
      chk("tick spacing", 4079, 4080, g);
      // A monitor break holds the watchdog while the service test runs.
      @(posedge clk);
      cfg.break_watchdog_disable <= 1'b1;
      break_active <= 1'b1;
      monitor_mode <= 1'b1;
      tick_gap(100, g);
      chk("tick after service", 4150, 4200, g);
      @(posedge clk);
      break_active <= 1'b0;
      monitor_mode <= 1'b0;
      $display("test watchdog done");
      for (k = 0; k < 2; k++) begin
         @(posedge clk);
         cpu <= 21'h000001;
         cfg.stop_enable <= 1'b1;
         cfg.short_stop_recovery <= (k == 0);
         @(posedge clk);
         cpu.stop_exec <= 1'b0;
         repeat (5) @(posedge clk);
         chk("stopped clocks", 0, 0, {bus_clk_en, osc_enable});
         wake_event <= 1'b1;
         @(posedge clk);
         wake_event <= 1'b0;
         for (n_off = 0; n_off < 5000 && bus_clk_en !== 1'b1; n_off++) @(posedge clk);
         chk("stop recovery", k ? 4096 : 32, k ? 4099 : 35, n_off);
      end
      $display("test stop done");
      pull_low <= 1'b1;
      repeat (10) @(posedge clk);
      chk("pin reset held", 1, 1, internal_reset);
      pull_low <= 1'b0;
      repeat (5) @(posedge clk);
      chk("pin reset ended", 0, 0, internal_reset);
      chk("pin cause", 1, 1, cause.pin);
      cfg.reset_pin_enable <= 1'b0;
      pull_low <= 1'b1;
      repeat (10) @(posedge clk);
      chk("pin disabled", 0, 0, internal_reset);
      pull_low <= 1'b0;
      $display("test pin_reset done");
      wrap_up();
   end

   // ====
   // A hang is cut short well beyond the expected run length.
   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      $display("CHECK FAILED run length expected finish seen timeout");
      wrap_up();
   end
endmodule : irs_sequencer_tb
